/* hdl/swric_top.sv */
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
// Function
// RULE_01: counter keeps counting in sleep only in asynchronous external-clock mode.
// RULE_02: software sets run, rollover enable and group enable before timer wake.
// RULE_03: rollover in sleep wakes core; with global enable it vectors to 0004h.
// RULE_04: comparator enabled before sleep stays active through sleep.
// RULE_05: clearing comparator_on switches the comparator off.
// RULE_06: comparator change wakes device when its enable and group enable set.
// RULE_07: after wake the next instruction runs before any vectoring.
// RULE_08: every reset returns second comparator control to off.
// RULE_09: six reset kinds are told apart and recorded.
// RULE_10: unaffected registers keep value through all resets but power-on.
// RULE_11: most registers load reset values on all device resets.
// RULE_12: watchdog expiry in sleep wakes without register reset.
// RULE_13: expired and sleep flags set per reset kind to show cause.
// RULE_14: external reset pin filters pulses shorter than minimum width.
// RULE_15: edge flag sampled by interrupt logic once per cycle in first quarter.
// RULE_16: latency 3 cycles synchronous, 3 to 4 asynchronous, any instruction.
// RULE_17: edge flag may set only during fourth through first quarter.
// RULE_18: counter rolls FFFFh to 0000h and sets rollover flag; software clears.
// RULE_19: request is global enable and core sources or group-enabled peripherals.
// RULE_20: wake on any enabled flagged source regardless of global enable.
module swric_top #(
  parameter int FILTER_CYC = swric_pkg::PIN_FILTER_CYC
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // event sources
  input  wire logic        ext_count_tick,
  input  wire logic        cmp_out,
  input  wire logic        ext_edge_event,
  input  wire logic        t0_overflow,
  input  wire logic [5:0]  pin_change,
  // reset sources
  input  wire logic        external_reset_pin_n,
  input  wire logic        watchdog_expire,
  input  wire logic        brown_out_reset,
  // core side
  output logic             irq_req,
  output logic             wake_pulse,
  output logic             vector_pulse,
  output logic      [12:0] vector_addr,
  output logic             core_sleep,
  output logic             device_reset,
  output logic             comparator_enable,
  output logic             vref_enable
);

  // bus state
  logic        busy_q;
  logic        wr_q;
  logic [7:0]  addr_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;
  logic        hresp_q;

  // registers
  logic [7:0]  interrupt_control_q;
  logic [7:0]  ioc_q;
  logic [7:0]  pflags_q;
  logic [7:0]  penable_q;
  logic [7:0]  cnt_cfg_q;
  logic [7:0]  cmp_1st_q;
  logic [7:0]  cmp_2nd_q;
  logic [15:0] cnt_q;
  logic        to_q;
  logic        pd_q;
  logic [2:0]  cause_q;

  // core timing and control
  logic [1:0]  phase_q;
  logic        sleep_q;
  logic        ext_pend_q;
  logic        cmp_prev_q;
  logic [1:0]  lat_q;
  logic        sr_q;
  logic [$clog2(FILTER_CYC + 1) - 1:0] filt_q;

  // output flops
  logic        irq_req_q;
  logic        wake_q;
  logic        vector_q;
  logic [12:0] vector_addr_q;
  logic        device_reset_q;

  // combinational terms
  logic        accept;
  logic        rst_all;
  logic        instr_tick;
  logic        cnt_tick;
  logic        cnt_roll;
  logic        set_t0;
  logic        set_ext;
  logic        set_chg;
  logic        set_cmp;
  logic        core_src;
  logic        periph_src;
  logic        any_src;
  logic        irq_now;
  logic        vector_fire;
  logic        pin_active;
  logic        wdt_run;
  logic        wdt_sleep;
  logic        soft_rst;
  logic        sleep_cmd;
  logic [7:0]  rd_byte;

  function automatic logic we(input logic [7:0] ofs);
    we = busy_q && wr_q && (addr_q == ofs);
  endfunction

  assign accept  = hsel && htrans[1] && hready;
  assign rst_all = srst || sr_q; // RULE_11

  // ---------------- bus slave ----------------
  // one wait state so a write always lands before the next read samples it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      busy_q      <= 1'b0;
      wr_q        <= 1'b0;
      addr_q      <= 8'h00;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      busy_q      <= accept;
      hreadyout_q <= !accept;
      hresp_q     <= 1'b0;
      if (accept) begin
        wr_q   <= hwrite;
        addr_q <= {haddr[7:2], 2'b00};
      end
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    unique case (addr_q)
      swric_pkg::OFS_INTERRUPT_CONTROL:  rd_byte = interrupt_control_q;
      swric_pkg::OFS_IOC:     rd_byte = ioc_q;
      swric_pkg::OFS_PFLAGS:  rd_byte = pflags_q;
      swric_pkg::OFS_PENABLE: rd_byte = penable_q;
      swric_pkg::OFS_CNT_LO:  rd_byte = cnt_q[7:0];
      swric_pkg::OFS_CNT_HI:  rd_byte = cnt_q[15:8];
      swric_pkg::OFS_CNT_CFG: rd_byte = cnt_cfg_q;
      swric_pkg::OFS_CMP_1ST: rd_byte = cmp_1st_q;
      swric_pkg::OFS_CMP_2ND: rd_byte = cmp_2nd_q;
      swric_pkg::OFS_RST_STS: rd_byte = {3'h0, to_q, pd_q, cause_q};
      swric_pkg::OFS_CORE:    rd_byte = {7'h00, sleep_q};
      default:                rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (busy_q && !wr_q) begin
      hrdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // ---------------- quarter phases ----------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      phase_q <= swric_pkg::PH_Q1;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  assign instr_tick = (phase_q == swric_pkg::PH_Q4);

  // ---------------- reset sources ----------------
  // pin pulses shorter than the filter never reach the reset tree
  always_ff @(posedge core_clk) begin
    if (srst || external_reset_pin_n) begin
      filt_q <= '0;
    end else if (filt_q != FILTER_CYC[$bits(filt_q) - 1:0]) begin
      filt_q <= filt_q + 1'b1; // RULE_14
    end
  end

  assign pin_active = !external_reset_pin_n &&
                      (filt_q == FILTER_CYC[$bits(filt_q) - 1:0]); // RULE_14
  assign wdt_run    = watchdog_expire && !sleep_q;
  assign wdt_sleep  = watchdog_expire && sleep_q; // RULE_12
  assign soft_rst   = !srst && (pin_active || wdt_run || brown_out_reset);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sr_q           <= 1'b0;
      device_reset_q <= 1'b1;
    end else begin
      sr_q           <= soft_rst;
      device_reset_q <= soft_rst;
    end
  end

  // cause flags live outside the reset tree so the soft resets cannot wipe them
  always_ff @(posedge core_clk) begin
    if (srst) begin
      to_q    <= 1'b1;
      pd_q    <= 1'b1;
      cause_q <= swric_pkg::SWRIC_CAUSE_POR; // RULE_09
    end else if (brown_out_reset) begin
      to_q    <= 1'b1;
      pd_q    <= 1'b1;
      cause_q <= swric_pkg::SWRIC_CAUSE_BOR; // RULE_09
    end else if (watchdog_expire) begin
      to_q    <= 1'b0; // RULE_13
      pd_q    <= !sleep_q;
      cause_q <= sleep_q ? swric_pkg::SWRIC_CAUSE_WDT_SLEEP : swric_pkg::SWRIC_CAUSE_WDT_RUN;
    end else if (pin_active && !sr_q) begin
      if (sleep_q) begin
        to_q <= 1'b1; // RULE_13
        pd_q <= 1'b0;
      end
      cause_q <= sleep_q ? swric_pkg::SWRIC_CAUSE_PIN_SLEEP : swric_pkg::SWRIC_CAUSE_PIN_RUN;
    end else if (sleep_cmd) begin
      to_q <= 1'b1;
      pd_q <= 1'b0;
    end
  end

  // ---------------- sources ----------------
  assign set_t0  = t0_overflow;
  assign set_chg = |(pin_change & ioc_q[5:0]);
  assign set_ext = ext_pend_q &&
                   (phase_q == swric_pkg::PH_Q4 || phase_q == swric_pkg::PH_Q1); // RULE_17
  assign set_cmp = cmp_1st_q[swric_pkg::CMPON_BIT] && (cmp_out != cmp_prev_q); // RULE_06

  // edge events are held until the q4-q1 window opens
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      ext_pend_q <= 1'b0;
    end else if (ext_edge_event) begin
      ext_pend_q <= 1'b1;
    end else if (set_ext) begin
      ext_pend_q <= 1'b0;
    end
  end

  // level tracked always, so switching the comparator on never sees a stale edge
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      cmp_prev_q <= 1'b0;
    end else begin
      cmp_prev_q <= cmp_out; // RULE_04
    end
  end

  // ---------------- counter ----------------
  assign cnt_tick = cnt_cfg_q[swric_pkg::RUN_BIT] &&
                    (cnt_cfg_q[swric_pkg::EXTSRC_BIT] ? ext_count_tick : instr_tick) &&
                    (!sleep_q || (cnt_cfg_q[swric_pkg::EXTSRC_BIT] &&
                                  cnt_cfg_q[swric_pkg::ASYNC_BIT])); // RULE_01
  assign cnt_roll = cnt_tick && (cnt_q == 16'hffff);

  // counter pair survives every reset except power-on
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_q <= swric_pkg::CNT_RST; // RULE_10
    end else if (we(swric_pkg::OFS_CNT_LO)) begin
      cnt_q[7:0] <= hwdata[7:0];
    end else if (we(swric_pkg::OFS_CNT_HI)) begin
      cnt_q[15:8] <= hwdata[7:0];
    end else if (cnt_tick) begin
      cnt_q <= cnt_q + 16'h0001; // RULE_18
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      cnt_cfg_q <= swric_pkg::CNT_CFG_RST; // RULE_11
    end else if (we(swric_pkg::OFS_CNT_CFG)) begin
      cnt_cfg_q <= {5'h00, hwdata[2:0]};
    end
  end

  // ---------------- comparator control ----------------
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      cmp_1st_q <= swric_pkg::CMP_1ST_RST;
    end else if (we(swric_pkg::OFS_CMP_1ST)) begin
      cmp_1st_q <= hwdata[7:0]; // RULE_05
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      cmp_2nd_q <= swric_pkg::CMP_2ND_RST; // RULE_08
    end else if (we(swric_pkg::OFS_CMP_2ND)) begin
      cmp_2nd_q <= hwdata[7:0];
    end
  end

  // ---------------- flags and enables ----------------
  // hardware sets win over a software clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      interrupt_control_q <= swric_pkg::INTERRUPT_CONTROL_RST;
    end else begin
      if (we(swric_pkg::OFS_INTERRUPT_CONTROL)) begin
        interrupt_control_q <= hwdata[7:0] | {5'h00, set_t0, set_ext, set_chg};
      end else begin
        interrupt_control_q <= interrupt_control_q | {5'h00, set_t0, set_ext, set_chg};
      end
      if (vector_fire) begin
        interrupt_control_q[swric_pkg::GIE_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      ioc_q <= swric_pkg::IOC_RST;
    end else if (we(swric_pkg::OFS_IOC)) begin
      ioc_q <= hwdata[7:0] & swric_pkg::IOC_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      pflags_q <= swric_pkg::PFLAGS_RST;
    end else if (we(swric_pkg::OFS_PFLAGS)) begin
      pflags_q <= (hwdata[7:0] & swric_pkg::PERIPH_MASK) |
                  {4'h0, set_cmp, 2'b00, cnt_roll}; // RULE_18
    end else begin
      pflags_q <= pflags_q | {4'h0, set_cmp, 2'b00, cnt_roll};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      penable_q <= swric_pkg::PENABLE_RST;
    end else if (we(swric_pkg::OFS_PENABLE)) begin
      penable_q <= hwdata[7:0] & swric_pkg::PERIPH_MASK;
    end
  end

  // ---------------- request and wake ----------------
  assign core_src = (interrupt_control_q[swric_pkg::T0IE_BIT] && interrupt_control_q[swric_pkg::T0F_BIT]) ||
                    (interrupt_control_q[swric_pkg::EXIE_BIT] && interrupt_control_q[swric_pkg::EXF_BIT]) ||
                    (interrupt_control_q[swric_pkg::CHIE_BIT] && interrupt_control_q[swric_pkg::CHF_BIT]);
  assign periph_src = interrupt_control_q[swric_pkg::PERIPHERAL_GROUP_ENABLE_BIT] &&
                      (|(pflags_q & penable_q & swric_pkg::PERIPH_MASK)); // RULE_06
  assign any_src = core_src || periph_src;
  assign irq_now = interrupt_control_q[swric_pkg::GIE_BIT] && any_src; // RULE_19
  assign sleep_cmd = we(swric_pkg::OFS_CORE) && hwdata[swric_pkg::SLEEP_BIT];

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      sleep_q <= 1'b0;
      wake_q  <= 1'b0;
    end else begin
      wake_q <= sleep_q && (any_src || wdt_sleep); // RULE_20
      if (sleep_q && (any_src || wdt_sleep)) begin
        sleep_q <= 1'b0; // RULE_03
      end else if (sleep_cmd) begin
        sleep_q <= 1'b1;
      end
    end
  end

  // latency counted in instruction cycles from the q1 sample; a woken core
  // always gets at least one instruction before the vector
  assign vector_fire = (lat_q == 2'h1) && instr_tick && !sleep_q;

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      lat_q <= 2'h0;
    end else if (!irq_now) begin
      lat_q <= 2'h0;
    end else if (lat_q == 2'h0 && phase_q == swric_pkg::PH_Q1 && !sleep_q) begin
      lat_q <= swric_pkg::SYNC_LAT_TCY[1:0]; // RULE_15
    end else if (lat_q != 2'h0 && instr_tick) begin
      lat_q <= lat_q - 2'h1; // RULE_16
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      irq_req_q     <= 1'b0;
      vector_q      <= 1'b0;
      vector_addr_q <= 13'h0000;
    end else begin
      irq_req_q <= irq_now;
      vector_q  <= vector_fire; // RULE_07
      if (vector_fire) begin
        vector_addr_q <= swric_pkg::IRQ_VECTOR; // RULE_03
      end
    end
  end

  // ---------------- outputs ----------------
  logic cmp_en_q;
  logic vref_q;

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      cmp_en_q <= 1'b0;
      vref_q   <= 1'b0;
    end else begin
      cmp_en_q <= cmp_1st_q[swric_pkg::CMPON_BIT]; // RULE_05
      vref_q   <= cmp_2nd_q[swric_pkg::VREF_BIT];
    end
  end

  assign hrdata            = hrdata_q;
  assign hreadyout         = hreadyout_q;
  assign hresp             = hresp_q;
  assign irq_req           = irq_req_q;
  assign wake_pulse        = wake_q;
  assign vector_pulse      = vector_q;
  assign vector_addr       = vector_addr_q;
  assign core_sleep        = sleep_q;
  assign device_reset      = device_reset_q;
  assign comparator_enable = cmp_en_q;
  assign vref_enable       = vref_q;

endmodule

/* hdl/swric_pkg.sv */
package swric_pkg;

  // register byte addresses, one aligned word each
  localparam logic [7:0] OFS_INTERRUPT_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_IOC     = 8'h04;
  localparam logic [7:0] OFS_PFLAGS  = 8'h08;
  localparam logic [7:0] OFS_PENABLE = 8'h0c;
  localparam logic [7:0] OFS_CNT_LO  = 8'h10;
  localparam logic [7:0] OFS_CNT_HI  = 8'h14;
  localparam logic [7:0] OFS_CNT_CFG = 8'h18;
  localparam logic [7:0] OFS_CMP_1ST = 8'h1c;
  localparam logic [7:0] OFS_CMP_2ND = 8'h20;
  localparam logic [7:0] OFS_RST_STS = 8'h24;
  localparam logic [7:0] OFS_CORE    = 8'h28;

  // reset values
  localparam logic [7:0] INTERRUPT_CONTROL_RST  = 8'h00;
  localparam logic [7:0] IOC_RST     = 8'h00;
  localparam logic [7:0] PFLAGS_RST  = 8'h00;
  localparam logic [7:0] PENABLE_RST = 8'h00;
  localparam logic [7:0] CNT_CFG_RST = 8'h00;
  localparam logic [7:0] CMP_1ST_RST = 8'h00;
  localparam logic [7:0] CMP_2ND_RST = 8'h00;
  localparam logic [15:0] CNT_RST    = 16'h0000;

  // interrupt_control fields
  localparam int GIE_BIT  = 7;
  localparam int PERIPHERAL_GROUP_ENABLE_BIT = 6;
  localparam int T0IE_BIT = 5;
  localparam int EXIE_BIT = 4;
  localparam int CHIE_BIT = 3;
  localparam int T0F_BIT  = 2;
  localparam int EXF_BIT  = 1;
  localparam int CHF_BIT  = 0;

  // peripheral flag / enable fields
  localparam int CMPF_BIT = 3;
  localparam int ROLF_BIT = 0;
  localparam logic [7:0] PERIPH_MASK = 8'h09;
  localparam logic [7:0] IOC_MASK    = 8'h3f;

  // counter config, comparator and core control fields
  localparam int RUN_BIT    = 0;
  localparam int EXTSRC_BIT = 1;
  localparam int ASYNC_BIT  = 2;
  localparam int CMPON_BIT  = 7;
  localparam int VREF_BIT   = 0;
  localparam int SLEEP_BIT  = 0;

  // reset status fields and cause codes
  localparam int TO_BIT = 4;
  localparam int PD_BIT = 3;
  typedef enum logic [2:0] {
    SWRIC_CAUSE_POR, SWRIC_CAUSE_WDT_RUN, SWRIC_CAUSE_WDT_SLEEP,
    SWRIC_CAUSE_PIN_RUN, SWRIC_CAUSE_PIN_SLEEP, SWRIC_CAUSE_BOR
  } swric_cause_t;

  // timing
  localparam int CLK_PERIOD_NS   = 100;
  localparam int PIN_FILTER_NS   = 2000;
  localparam int PIN_FILTER_CYC  = (PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_LAT_TCY    = 3;
  localparam logic [1:0] PH_Q1   = 2'h0;
  localparam logic [1:0] PH_Q4   = 2'h3;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

endpackage

/* tb/swric_props.sv */
`timescale 1ns/1ps
module swric_props (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        srst,
  // bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic        hreadyout,
  // core side
  input wire logic        irq_req,
  input wire logic        wake_pulse,
  input wire logic        vector_pulse,
  input wire logic [12:0] vector_addr,
  input wire logic        core_sleep,
  input wire logic        device_reset,
  input wire logic        comparator_enable,
  input wire logic        vref_enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_taken;
    hsel && htrans[1] && hready;
  endsequence
  sequence s_data_phase;
    !hreadyout ##1 hreadyout;
  endsequence

  chk_bus_wait: assert property (s_taken |=> s_data_phase)
    else $error("data phase not one wait cycle");
  chk_vector_addr: assert property (
    vector_pulse |-> ##[0:1] vector_addr == swric_pkg::IRQ_VECTOR)
    else $error("vector address wrong");
  // request must already have been high 8 cycles before the vector pulse
  chk_irq_latency: assert property (vector_pulse |-> $past(irq_req, 8))
    else $error("vector too soon after request");
  chk_wake_source: assert property (
    wake_pulse |-> $past(core_sleep) || $past(core_sleep, 2))
    else $error("wake without sleep");
  chk_wake_order: assert property (wake_pulse |=> !vector_pulse [*4])
    else $error("vector before next instruction");
  chk_vector_gie: assert property (vector_pulse |-> ##[1:3] !irq_req)
    else $error("request stays after vectoring");
  chk_cmp_sleep: assert property (
    core_sleep && comparator_enable && !device_reset |=> comparator_enable)
    else $error("comparator dropped in sleep");
  chk_reset_cmp: assert property (
    device_reset |-> ##[0:2] !comparator_enable && !vref_enable)
    else $error("comparator left on by reset");
endmodule

/* tb/swric_partner.sv */
`timescale 1ns/1ps
module swric_partner (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // bench commands
  input  wire logic       ev_go,
  input  wire logic [2:0] ev_sel,
  input  wire logic [7:0] ev_len,
  // sources toward the block
  output logic            ext_count_tick,
  output logic            cmp_out,
  output logic            ext_edge_event,
  output logic            t0_overflow,
  output logic [5:0]      pin_change,
  output logic            external_reset_pin_n,
  output logic            watchdog_expire,
  output logic            brown_out_reset
);
  logic [7:0] act_q = 8'h00;
  logic [7:0] left_q = 8'h00;
  logic       cmp_q = 1'b0;

  // one source at a time, held ev_len cycles
  always_ff @(posedge core_clk) begin
    if (srst || (!ev_go && left_q <= 8'h01)) begin
      act_q  <= 8'h00;
      left_q <= 8'h00;
    end else if (ev_go) begin
      act_q  <= 8'h01 << ev_sel;
      left_q <= ev_len;
    end else begin
      left_q <= left_q - 8'h01;
    end
  end

  // comparator level moves only on command
  always_ff @(posedge core_clk) begin
    if (srst) cmp_q <= 1'b0;
    else if (ev_go && ev_sel == 3'h7) cmp_q <= ~cmp_q;
  end

  assign ext_count_tick       = act_q[0];
  assign ext_edge_event       = act_q[1];
  assign t0_overflow          = act_q[2];
  assign watchdog_expire      = act_q[3];
  assign brown_out_reset      = act_q[4];
  assign external_reset_pin_n = ~act_q[5];
  assign pin_change           = {6{act_q[6]}};
  assign cmp_out              = cmp_q;
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  localparam int FILT = 2;
  logic        core_clk, srst, hsel, hwrite, hready, hreadyout, hresp, ev_go;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, ev_sel;
  logic [7:0]  ev_len;
  logic [5:0]  pin_change;
  logic [12:0] vector_addr;
  logic        ext_count_tick, cmp_out, ext_edge_event, t0_overflow, watchdog_expire;
  logic        external_reset_pin_n, brown_out_reset, irq_req, wake_pulse, vector_pulse;
  logic        core_sleep, device_reset, comparator_enable, vref_enable;
  int          errors, samples_checked, n;
  logic [7:0]  ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h1c, 8'h20, 8'h3c};
  logic [2:0]  rsel [4] = '{3'h3, 3'h5, 3'h5, 3'h4};
  logic [2:0]  rcau [4] = '{3'h1, 3'h4, 3'h3, 3'h5};
  logic [2:0]  isel [3] = '{3'h2, 3'h1, 3'h6};
  logic [7:0]  ien [3] = '{8'h20, 8'h10, 8'h08};
  logic [7:0]  ifl [3] = '{8'h04, 8'h02, 8'h01};

  assign hready = hreadyout;

  swric_top #(.FILTER_CYC(FILT)) uut (.core_clk, .srst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .ext_count_tick, .cmp_out,
    .ext_edge_event, .t0_overflow, .pin_change, .external_reset_pin_n, .watchdog_expire,
    .brown_out_reset, .irq_req, .wake_pulse, .vector_pulse, .vector_addr, .core_sleep,
    .device_reset, .comparator_enable, .vref_enable);
  swric_partner u_far (.core_clk, .srst, .ev_go, .ev_sel, .ev_len, .ext_count_tick,
    .cmp_out, .ext_edge_event, .t0_overflow, .pin_change, .external_reset_pin_n,
    .watchdog_expire, .brown_out_reset);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge core_clk);
  endtask

  // values seen right after the edge are the pre-edge ones
  task automatic hold();
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      errors++;
      complete_run();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    hold();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    hold();
    r = hrdata[7:0];
    chk("response", {7'h0, hresp}, 8'h00);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp,
                    input logic [7:0] m = 8'hff);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, r);
    chk(what, r & m, exp);
  endtask

  task automatic fire(input logic [2:0] s, input logic [7:0] len);
    ev_sel <= s;
    ev_len <= len;
    ev_go  <= 1'b1;
    tick(1);
    ev_go  <= 1'b0;
  endtask

  // a wanted event that never comes ends the run; absence checks pass need = 0
  task automatic wait_ev(input int s, input int lim, output int c, input bit need = 1'b1);
    for (c = 0; c < lim; c++) begin
      @(posedge core_clk);
      if ((s == 0 && wake_pulse === 1'b1) || (s == 1 && vector_pulse === 1'b1) ||
          (s == 2 && device_reset === 1'b1)) break;
    end
    if (need && c >= lim) begin
      errors++;
      complete_run();
    end
  endtask

  initial begin
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ev_go = 1'b0;
    ev_sel = 3'h0;
    ev_len = 8'h00;
    errors = 0;
    samples_checked = 0;
    tick(3);
    srst <= 1'b0;
    tick(1);
    foreach (ofs[i]) rd("reset value", ofs[i], 8'h00);
    rd("por cause", swric_pkg::OFS_RST_STS, 8'h00, 8'h07);
    wr(8'h3c, 8'haa);
    rd("unmapped", 8'h3c, 8'h00);
    $display("test registers done");
    wr(swric_pkg::OFS_CNT_CFG, 8'h07);
    wr(swric_pkg::OFS_CNT_LO, 8'hff);
    wr(swric_pkg::OFS_CNT_HI, 8'hff);
    wr(swric_pkg::OFS_PENABLE, 8'h01);
    wr(swric_pkg::OFS_INTERRUPT_CONTROL, 8'hc0);
    wr(swric_pkg::OFS_CORE, 8'h01);
    chk("sleeping", {7'h0, core_sleep}, 8'h01);
    fire(3'h0, 8'h01);
    wait_ev(0, 200, n);
    chk("timer wake", {7'h0, n < 200}, 8'h01);
    chk("awake", {7'h0, core_sleep}, 8'h00);
    wait_ev(1, 40, n);
    chk("vector", {7'h0, n < 40}, 8'h01);
    chk("vector address", vector_addr[7:0], 8'h04);
    rd("rollover flag", swric_pkg::OFS_PFLAGS, 8'h01);
    rd("count low", swric_pkg::OFS_CNT_LO, 8'h00);
    rd("count high", swric_pkg::OFS_CNT_HI, 8'h00);
    rd("global cleared", swric_pkg::OFS_INTERRUPT_CONTROL, 8'h40);
    wr(swric_pkg::OFS_PFLAGS, 8'h00);
    rd("flag cleared", swric_pkg::OFS_PFLAGS, 8'h00);
    $display("test timer wake done");
    wr(swric_pkg::OFS_CNT_CFG, 8'h03);
    wr(swric_pkg::OFS_CNT_LO, 8'hff);
    wr(swric_pkg::OFS_PENABLE, 8'h09);
    wr(swric_pkg::OFS_CMP_1ST, 8'h80);
    wr(swric_pkg::OFS_CORE, 8'h01);
    fire(3'h0, 8'h01);
    wait_ev(0, 30, n, 1'b0);
    chk("sync count no wake", {7'h0, n == 30}, 8'h01);
    fire(3'h7, 8'h01);
    wait_ev(0, 200, n);
    chk("comparator wake", {7'h0, n < 200}, 8'h01);
    wait_ev(1, 30, n, 1'b0);
    chk("no vector", {7'h0, n == 30}, 8'h01);
    rd("change flag", swric_pkg::OFS_PFLAGS, 8'h08);
    rd("count held", swric_pkg::OFS_CNT_LO, 8'hff);
    wr(swric_pkg::OFS_PFLAGS, 8'h00);
    wr(swric_pkg::OFS_CMP_1ST, 8'h00);
    tick(2);
    chk("comparator off", {7'h0, comparator_enable}, 8'h00);
    $display("test comparator wake done");
    wr(swric_pkg::OFS_CORE, 8'h01);
    fire(3'h3, 8'h01);
    wait_ev(0, 100, n);
    chk("watchdog wake", {7'h0, n < 100}, 8'h01);
    rd("wake status", swric_pkg::OFS_RST_STS, 8'h02);
    rd("kept enables", swric_pkg::OFS_PENABLE, 8'h09);
    fire(3'h5, 8'h01);
    tick(FILT + 8);
    rd("short pin pulse", swric_pkg::OFS_PENABLE, 8'h09);
    $display("test watchdog wake done");
    for (int i = 0; i < 4; i++) begin
      wr(swric_pkg::OFS_PENABLE, 8'h09);
      wr(swric_pkg::OFS_CMP_2ND, 8'h01);
      if (i == 1) wr(swric_pkg::OFS_CORE, 8'h01);
      tick(1);
      chk("vref on", {7'h0, vref_enable}, 8'h01);
      fire(rsel[i], rsel[i] == 3'h5 ? 8'h06 : 8'h01);
      wait_ev(2, FILT + 10, n);
      chk("reset pulse", {7'h0, n < FILT + 10}, 8'h01);
      tick(FILT + 10);
      rd("register reset", swric_pkg::OFS_PENABLE, 8'h00);
      rd("second control", swric_pkg::OFS_CMP_2ND, 8'h00);
      chk("vref off", {7'h0, vref_enable}, 8'h00);
      rd("reset cause", swric_pkg::OFS_RST_STS, {5'h0, rcau[i]}, 8'h07);
      rd("count kept", swric_pkg::OFS_CNT_LO, 8'hff);
    end
    $display("test reset kinds done");
    wr(swric_pkg::OFS_IOC, 8'h3f);
    for (int i = 0; i < 3; i++) begin
      wr(swric_pkg::OFS_INTERRUPT_CONTROL, ien[i]);
      fire(isel[i], 8'h01);
      tick(8);
      chk("request gated", {7'h0, irq_req}, 8'h00);
      rd("source flag", swric_pkg::OFS_INTERRUPT_CONTROL, ien[i] | ifl[i]);
      wr(swric_pkg::OFS_INTERRUPT_CONTROL, 8'h80 | ien[i] | ifl[i]);
      wait_ev(1, 40, n);
      chk("latency", {7'h0, n >= 8 && n <= 20}, 8'h01);
      wr(swric_pkg::OFS_INTERRUPT_CONTROL, 8'h00);
    end
    $display("test core sources done");
    complete_run();
  end
endmodule

bind swric_top swric_props u_props (.core_clk, .srst, .hsel, .htrans, .hready, .hreadyout,
  .irq_req, .wake_pulse, .vector_pulse, .vector_addr, .core_sleep, .device_reset,
  .comparator_enable, .vref_enable);
